// ---- logic/ass_consts.svh ----
// offsets, field positions, reset values and codes of the alert summary block
`ifndef ASS_CONSTS_SVH
`define ASS_CONSTS_SVH
`define ASS_OFS_IFS        8'h03
`define ASS_OFS_SUM        8'h02
`define ASS_IFS_RESET      16'h0000
`define ASS_IFS_W0C_MASK   16'hfe01
`define ASS_IFS_RW_MASK    16'h00f0
`define ASS_BIT_PEC_UP     15
`define ASS_BIT_PEC_DN     14
`define ASS_BIT_MAN_UP     13
`define ASS_BIT_MAN_DN     12
`define ASS_BIT_PAR_UP     11
`define ASS_BIT_PAR_DN     10
`define ASS_BIT_TWO_PATH   9
`define ASS_BIT_SPI        7
`define ASS_BIT_SCLK       6
`define ASS_BIT_OSC3       5
`define ASS_BIT_INTBUS     4
`define ASS_BIT_RJCT       0
`define ASS_SUM_PEC        5
`define ASS_SUM_LINK       4
`define ASS_SUM_CAL        3
`define ASS_SUM_CBAL       2
`define ASS_SUM_FAIL2      1
`define ASS_SUM_FAIL1      0
`define ASS_CFG_DUAL       2'h3
`define ASS_CB_ABORT       2'h3
`define ASS_CB_IDLE        2'h0
`define ASS_CB_RUN         2'h1
`endif

// ---- logic/ass_pkg.sv ----
// types of the alert summary block
package ass_pkg;
	typedef struct packed {
		logic up_pec;
		logic down_pec;
		logic up_manchester;
		logic down_manchester;
		logic up_parity;
		logic down_parity;
		logic two_path;
		logic rejected;
		logic spi_error;
		logic spi_crc;
		logic sclk;
		logic osc3;
		logic intbus;
	} ass_evt_s;
	typedef struct packed {
		logic adc_offset;
		logic ref_offset;
		logic thermal_offset;
		logic primary_gain;
		logic ref_gain;
	} ass_cal_s;
	typedef struct packed {
		logic timeout;
		logic temperature;
		logic notify;
		logic done;
	} ass_cb_s;
	typedef enum logic [1:0] {ASS_CB_IDLE_ST, ASS_CB_RUN_ST, ASS_CB_ABORT_ST} ass_cb_e;
endpackage

// ---- logic/ass_alert_status_summary.sv ----
// alert summary and interface fault status registers
`timescale 1ns/1ps
`include "ass_consts.svh"
// How it works
// RULE1: uart mode link summary ORs manchester, parity, two-path and rejected flags
// RULE2: spi mode link summary ORs spi, sclk, osc3, internal bus, rejected flags
// RULE3: packet check alert has its own bit, never feeds link summary
// RULE4: calibration summary bit 3 ORs the five calibration alerts
// RULE5: calibration summary clears only when all components clear; not writable
// RULE6: calibration error during balancing stops it, state 11, sets balancing calibration alert
// RULE7: balancing summary bit 2 ORs enabled, unmasked balancing alerts
// RULE8: balancing summary clears only when all its components clear
// RULE9: summary bit 1 ORs all sixteen bits of second failure-mode register
// RULE10: summary bit 0 ORs all sixteen bits of first failure-mode register
// RULE11: interface fault status register at 0x03, read/write, resets to zero
// RULE12: uart error and rejected flags clear on write zero; writing one keeps
// RULE13: uart mode up packet check failure discards and sets bit 15
// RULE14: dual-path config only, down packet check failure discards and sets bit 14
// RULE15: uart mode up manchester violation sets bit 13
// RULE16: dual-path config only, down manchester violation sets bit 12
// RULE17: host reads interface fault register on link summary and clears there
// RULE18: packet check alert ORs up, down and spi crc errors
// RULE19: unimplemented bits 8 and 3..1 read zero, writes ignored
module ass_alert_status_summary
	import ass_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// mode
	input  wire logic        interface_select,
	input  wire logic [1:0]  serial_path_config,
	// error events and calibration alerts
	input  wire ass_evt_s    evt,
	input  wire ass_cal_s    cal,
	input  wire logic [15:0] first_failure_mode_register,
	input  wire logic [15:0] second_failure_mode_register,
	// balancing
	input  wire logic        balancing_start,
	input  wire logic        balancing_finish,
	input  wire ass_cb_s     cb_alerts,
	input  wire logic [4:0]  cb_irq_enable,
	input  wire logic        cb_alert_clear,
	// status outputs
	output logic      [7:0]  alert_summary,
	output logic      [1:0]  balancing_active_state,
	output logic             balancing_calibration_alert,
	output logic             discard_up,
	output logic             discard_down
);
	logic [15:0] ifs;
	logic [15:0] next_ifs;
	logic        spi_crc;
	logic        next_spi_crc;
	ass_cb_e     cb_st;
	ass_cb_e     next_cb_st;
	logic        next_cbcal;
	logic [7:0]  next_sum;
	logic [15:0] next_rdata;
	logic [1:0]  next_cb_out;
	logic        next_disc_up;
	logic        next_disc_dn;
	logic        uart;
	logic        dual;
	logic        cal_any;
	logic        wr_ifs;

	function automatic logic w0c(input logic cur, input logic set, input logic wr, input logic wbit);
		w0c = set | (cur & ~(wr & ~wbit));
	endfunction

	assign uart    = interface_select;
	assign dual    = interface_select && (serial_path_config == `ASS_CFG_DUAL);
	assign cal_any = |cal; // RULE4
	assign wr_ifs  = reg_wr && (reg_addr == `ASS_OFS_IFS); // RULE11

	// interface fault status next value, set wins over clear
	always_comb
	begin
		next_ifs = ifs;
		next_ifs[`ASS_BIT_PEC_UP]   = w0c(ifs[`ASS_BIT_PEC_UP], uart && evt.up_pec, wr_ifs,
			reg_wdata[`ASS_BIT_PEC_UP]); // RULE13
		next_ifs[`ASS_BIT_PEC_DN]   = w0c(ifs[`ASS_BIT_PEC_DN], dual && evt.down_pec, wr_ifs,
			reg_wdata[`ASS_BIT_PEC_DN]); // RULE14
		next_ifs[`ASS_BIT_MAN_UP]   = w0c(ifs[`ASS_BIT_MAN_UP], uart && evt.up_manchester, wr_ifs,
			reg_wdata[`ASS_BIT_MAN_UP]); // RULE15
		next_ifs[`ASS_BIT_MAN_DN]   = w0c(ifs[`ASS_BIT_MAN_DN], dual && evt.down_manchester, wr_ifs,
			reg_wdata[`ASS_BIT_MAN_DN]); // RULE16
		next_ifs[`ASS_BIT_PAR_UP]   = w0c(ifs[`ASS_BIT_PAR_UP], uart && evt.up_parity, wr_ifs,
			reg_wdata[`ASS_BIT_PAR_UP]); // RULE12
		next_ifs[`ASS_BIT_PAR_DN]   = w0c(ifs[`ASS_BIT_PAR_DN], dual && evt.down_parity, wr_ifs,
			reg_wdata[`ASS_BIT_PAR_DN]); // RULE12
		next_ifs[`ASS_BIT_TWO_PATH] = w0c(ifs[`ASS_BIT_TWO_PATH], dual && evt.two_path, wr_ifs,
			reg_wdata[`ASS_BIT_TWO_PATH]); // RULE12
		next_ifs[`ASS_BIT_RJCT]     = w0c(ifs[`ASS_BIT_RJCT], evt.rejected, wr_ifs,
			reg_wdata[`ASS_BIT_RJCT]); // RULE12
		next_ifs[`ASS_BIT_SPI]      = w0c(ifs[`ASS_BIT_SPI], ~uart && evt.spi_error, wr_ifs,
			reg_wdata[`ASS_BIT_SPI]);
		next_ifs[`ASS_BIT_SCLK]     = w0c(ifs[`ASS_BIT_SCLK], ~uart && evt.sclk, wr_ifs,
			reg_wdata[`ASS_BIT_SCLK]);
		next_ifs[`ASS_BIT_OSC3]     = w0c(ifs[`ASS_BIT_OSC3], ~uart && evt.osc3, wr_ifs,
			reg_wdata[`ASS_BIT_OSC3]);
		next_ifs[`ASS_BIT_INTBUS]   = w0c(ifs[`ASS_BIT_INTBUS], ~uart && evt.intbus, wr_ifs,
			reg_wdata[`ASS_BIT_INTBUS]);
		next_ifs = next_ifs & (`ASS_IFS_W0C_MASK | `ASS_IFS_RW_MASK); // RULE19
		// spi crc error cleared by writing zero to the spi error bit 7 of the interface fault register
		next_spi_crc = w0c(spi_crc, ~uart && evt.spi_crc, wr_ifs, reg_wdata[`ASS_BIT_SPI]);
		next_disc_up = uart && evt.up_pec; // RULE13
		next_disc_dn = dual && evt.down_pec; // RULE14
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ifs          <= `ASS_IFS_RESET; // RULE11
			spi_crc      <= 1'b0;
			discard_up   <= 1'b0;
			discard_down <= 1'b0;
		end
		else
		begin
			ifs          <= next_ifs;
			spi_crc      <= next_spi_crc;
			discard_up   <= next_disc_up;
			discard_down <= next_disc_dn;
		end
	end

	// balancing state machine
	always_comb
	begin
		next_cb_st = cb_st;
		next_cbcal = balancing_calibration_alert & ~cb_alert_clear;
		case (cb_st)
			ASS_CB_IDLE_ST:
			begin
				if (balancing_start)
					next_cb_st = ASS_CB_RUN_ST;
			end
			ASS_CB_RUN_ST:
			begin
				if (cal_any)
				begin
					next_cb_st = ASS_CB_ABORT_ST; // RULE6
					next_cbcal = 1'b1; // RULE6
				end
				else if (balancing_finish)
					next_cb_st = ASS_CB_IDLE_ST;
			end
			ASS_CB_ABORT_ST:
			begin
				if (balancing_start)
					next_cb_st = ASS_CB_RUN_ST;
			end
			default:
				next_cb_st = ASS_CB_IDLE_ST;
		endcase
		case (next_cb_st)
			ASS_CB_RUN_ST:   next_cb_out = `ASS_CB_RUN;
			ASS_CB_ABORT_ST: next_cb_out = `ASS_CB_ABORT; // RULE6
			default:         next_cb_out = `ASS_CB_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cb_st                       <= ASS_CB_IDLE_ST;
			balancing_active_state      <= `ASS_CB_IDLE;
			balancing_calibration_alert <= 1'b0;
		end
		else
		begin
			cb_st                       <= next_cb_st;
			balancing_active_state      <= next_cb_out;
			balancing_calibration_alert <= next_cbcal;
		end
	end

	// summary bits and read data
	always_comb
	begin
		next_sum = 8'h00;
		next_sum[`ASS_SUM_PEC] = next_ifs[`ASS_BIT_PEC_UP] | next_ifs[`ASS_BIT_PEC_DN] | next_spi_crc; // RULE18
		if (uart)
			next_sum[`ASS_SUM_LINK] = next_ifs[`ASS_BIT_MAN_UP] | next_ifs[`ASS_BIT_MAN_DN] |
				next_ifs[`ASS_BIT_PAR_UP] | next_ifs[`ASS_BIT_PAR_DN] |
				next_ifs[`ASS_BIT_TWO_PATH] | next_ifs[`ASS_BIT_RJCT]; // RULE1 RULE3
		else
			next_sum[`ASS_SUM_LINK] = next_ifs[`ASS_BIT_SPI] | next_ifs[`ASS_BIT_SCLK] |
				next_ifs[`ASS_BIT_OSC3] | next_ifs[`ASS_BIT_INTBUS] | next_ifs[`ASS_BIT_RJCT]; // RULE2 RULE3
		next_sum[`ASS_SUM_CAL]   = cal_any; // RULE4 RULE5
		next_sum[`ASS_SUM_CBAL]  = |({cb_alerts.timeout, cb_alerts.temperature, next_cbcal,
			cb_alerts.notify, cb_alerts.done} & cb_irq_enable); // RULE7 RULE8
		next_sum[`ASS_SUM_FAIL2] = |second_failure_mode_register; // RULE9
		next_sum[`ASS_SUM_FAIL1] = |first_failure_mode_register; // RULE10
		next_rdata = 16'h0000;
		if (reg_rd && reg_addr == `ASS_OFS_IFS)
			next_rdata = ifs; // RULE19
		else if (reg_rd && reg_addr == `ASS_OFS_SUM)
			next_rdata = {8'h00, alert_summary};
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			alert_summary <= 8'h00;
			reg_rdata     <= 16'h0000;
		end
		else
		begin
			alert_summary <= next_sum;
			reg_rdata     <= next_rdata;
		end
	end

	sequence up_pec_seen;
		uart && evt.up_pec;
	endsequence

	flag_up_pec_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE13
		up_pec_seen |=> ifs[`ASS_BIT_PEC_UP] && discard_up)
		else $error("up pec flag not set");
	sticky_w1_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
		ifs[`ASS_BIT_MAN_UP] && !(wr_ifs && !reg_wdata[`ASS_BIT_MAN_UP]) |=> ifs[`ASS_BIT_MAN_UP])
		else $error("manchester flag lost");
	clear_w0_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
		wr_ifs && !reg_wdata[`ASS_BIT_RJCT] && !evt.rejected |=> !ifs[`ASS_BIT_RJCT])
		else $error("rejected flag not cleared");
	dn_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE14
		!dual && !ifs[`ASS_BIT_PEC_DN] |=> !ifs[`ASS_BIT_PEC_DN])
		else $error("down pec set outside dual mode");
	man_dn_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE16
		!dual && !ifs[`ASS_BIT_MAN_DN] |=> !ifs[`ASS_BIT_MAN_DN])
		else $error("down manchester set outside dual mode");
	unused_bits_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE19
		ifs[8] == 1'b0 && ifs[3:1] == 3'h0)
		else $error("unimplemented bit set");
	fmea_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE10
		alert_summary[`ASS_SUM_FAIL1] == |$past(first_failure_mode_register))
		else $error("first failure-mode summary wrong");
	cal_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
		$past(cal_any) |-> alert_summary[`ASS_SUM_CAL])
		else $error("cal summary missing");
	cb_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
		cb_st == ASS_CB_RUN_ST && cal_any |=> balancing_active_state == `ASS_CB_ABORT
		&& balancing_calibration_alert)
		else $error("balancing not aborted");
	pec_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE18
		ifs[`ASS_BIT_PEC_UP] |-> ##1 alert_summary[`ASS_SUM_PEC] || $past(wr_ifs))
		else $error("pec summary missing");

	sequence dn_pec_seen;
		dual && evt.down_pec;
	endsequence
	sequence uart_link_quiet;
		uart ##1 (ifs[13:9] == 5'h00 && !ifs[`ASS_BIT_RJCT]);
	endsequence
	sequence pec_quiet;
		1'b1 ##1 (ifs[`ASS_BIT_PEC_UP] == 1'b0 && ifs[`ASS_BIT_PEC_DN] == 1'b0 && !spi_crc);
	endsequence
	sequence cb_quiet;
		(cb_alerts == 4'h0) ##1 !balancing_calibration_alert;
	endsequence

	flag_dn_pec_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE14
		dn_pec_seen |=> ifs[`ASS_BIT_PEC_DN] && discard_down)
		else $error("down pec flag not set");
	flag_man_up_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE15
		uart && evt.up_manchester |=> ifs[`ASS_BIT_MAN_UP])
		else $error("up manchester flag not set");
	flag_man_dn_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE16
		dual && evt.down_manchester |=> ifs[`ASS_BIT_MAN_DN])
		else $error("down manchester flag not set");
	up_pec_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE13
		!uart && !ifs[`ASS_BIT_PEC_UP] |=> !ifs[`ASS_BIT_PEC_UP])
		else $error("up pec set in spi mode");
	man_up_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE15
		!uart && !ifs[`ASS_BIT_MAN_UP] |=> !ifs[`ASS_BIT_MAN_UP])
		else $error("up manchester set in spi mode");
	up_discard_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE13
		!(uart && evt.up_pec) |=> !discard_up)
		else $error("up discard without pec error");
	dn_discard_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE14
		!(dual && evt.down_pec) |=> !discard_down)
		else $error("down discard without pec error");
	link_uart_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
		uart |=> alert_summary[`ASS_SUM_LINK] == (|ifs[13:9] || ifs[`ASS_BIT_RJCT]))
		else $error("uart link summary wrong");
	link_spi_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
		!uart |=> alert_summary[`ASS_SUM_LINK] == (|ifs[7:4] || ifs[`ASS_BIT_RJCT]))
		else $error("spi link summary wrong");
	pec_apart_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
		uart_link_quiet |-> !alert_summary[`ASS_SUM_LINK])
		else $error("pec feeds link summary");
	pec_dn_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE18
		ifs[`ASS_BIT_PEC_DN] && !wr_ifs |=> alert_summary[`ASS_SUM_PEC])
		else $error("down pec summary missing");
	crc_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE18
		spi_crc && !wr_ifs |=> alert_summary[`ASS_SUM_PEC])
		else $error("crc summary missing");
	pec_none_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE18
		pec_quiet |-> !alert_summary[`ASS_SUM_PEC])
		else $error("pec summary without cause");
	crc_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE18
		!uart && evt.spi_crc |=> spi_crc)
		else $error("crc error not held");
	spi_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
		!uart && evt.spi_error |=> ifs[`ASS_BIT_SPI])
		else $error("spi error flag not set");
	rjct_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
		ifs[`ASS_BIT_RJCT] && !(wr_ifs && !reg_wdata[`ASS_BIT_RJCT]) |=> ifs[`ASS_BIT_RJCT])
		else $error("rejected flag lost");
	pec_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
		wr_ifs && !reg_wdata[`ASS_BIT_PEC_UP] && !evt.up_pec |=> !ifs[`ASS_BIT_PEC_UP])
		else $error("up pec flag not cleared");
	par_up_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
		!uart && !ifs[`ASS_BIT_PAR_UP] |=> !ifs[`ASS_BIT_PAR_UP])
		else $error("up parity set in spi mode");
	cal_sum_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
		!cal_any |=> !alert_summary[`ASS_SUM_CAL])
		else $error("cal summary not cleared");
	cbcal_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
		balancing_calibration_alert && !cb_alert_clear |=> balancing_calibration_alert)
		else $error("balancing cal alert lost");
	cb_done_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
		cb_alerts.done && cb_irq_enable[0] |=> alert_summary[`ASS_SUM_CBAL])
		else $error("balancing summary missing");
	cb_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
		cb_irq_enable == 5'h00 |=> !alert_summary[`ASS_SUM_CBAL])
		else $error("masked balancing alert shown");
	cb_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
		cb_quiet |-> !alert_summary[`ASS_SUM_CBAL])
		else $error("balancing summary not cleared");
	second_fm_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE9
		alert_summary[`ASS_SUM_FAIL2] == |$past(second_failure_mode_register))
		else $error("second failure-mode summary wrong");
	rdata_ifs_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE11
		reg_rd && reg_addr == `ASS_OFS_IFS |=> reg_rdata == $past(ifs))
		else $error("fault status read wrong");
	rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE11
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data without read");
	rdata_gap_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE19
		reg_rd && reg_addr == `ASS_OFS_IFS |=> reg_rdata[8] == 1'b0 && reg_rdata[3:1] == 3'h0)
		else $error("unimplemented bit read nonzero");
endmodule

// ---- tb/ass_host_model.sv ----
// host side register access model
`timescale 1ns/1ps
module ass_host_model (
	// clock
	input  wire logic        ref_clk,
	// register port
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [7:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata
);
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	// write, then leave the data lines showing the inverse
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// read, data taken the cycle after the strobe
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// ---- tb/ass_alert_status_summary_test.sv ----
// self-checking bench of the alert summary block
`timescale 1ns/1ps
`include "ass_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module ass_alert_status_summary_test
	import ass_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr, reg_rd, interface_select = 1'b1, balancing_start = 1'b0, balancing_finish = 1'b0;
	logic cb_alert_clear = 1'b0, balancing_calibration_alert, discard_up, discard_down;
	logic [7:0] reg_addr, alert_summary;
	logic [15:0] reg_wdata, reg_rdata, first_fm = 16'h0000, second_fm = 16'h0000, d;
	logic [1:0] serial_path_config = 2'h3, balancing_active_state;
	logic [4:0] cb_irq_enable = 5'h00;
	ass_evt_s evt = '0;
	ass_cal_s cal = '0;
	ass_cb_s cb_alerts = '0;
	int bad_count = 0;
	int n_tests = 0;
	always #25 ref_clk = ~ref_clk;
	ass_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	ass_alert_status_summary dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.interface_select(interface_select), .serial_path_config(serial_path_config), .evt(evt), .cal(cal),
		.first_failure_mode_register(first_fm), .second_failure_mode_register(second_fm),
		.balancing_start(balancing_start), .balancing_finish(balancing_finish), .cb_alerts(cb_alerts),
		.cb_irq_enable(cb_irq_enable), .cb_alert_clear(cb_alert_clear), .alert_summary(alert_summary),
		.balancing_active_state(balancing_active_state),
		.balancing_calibration_alert(balancing_calibration_alert), .discard_up(discard_up),
		.discard_down(discard_down));
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task pulse(input ass_evt_s e);
		tick(1);
		evt = e;
		tick(1);
		evt = '0;
	endtask
	// one event: summary, discards, flag readback, write-one keep, write-zero clear
	task one(input int i, input logic [15:0] m, input logic [1:0] s, input logic [1:0] ds);
		pulse(ass_evt_s'(13'h1 << i));
		`CHK(alert_summary[5:4], s)
		`CHK({discard_up, discard_down}, ds)
		host.rd(`ASS_OFS_IFS, d);
		`CHK(d, m)
		host.wr(`ASS_OFS_IFS, 16'hffff);
		host.rd(`ASS_OFS_IFS, d);
		`CHK(d, m)
		host.wr(`ASS_OFS_IFS, 16'h0000);
		host.rd(`ASS_OFS_IFS, d);
		`CHK(d, 16'h0000)
	endtask
	task t_reset;
		`CHK(alert_summary, 8'h00)
		host.wr(`ASS_OFS_IFS, 16'h010e);
		host.rd(`ASS_OFS_IFS, d);
		`CHK(d, `ASS_IFS_RESET)
	endtask
	task t_uart;
		one(12, 16'h8000, 2'b10, 2'b10);
		one(11, 16'h4000, 2'b10, 2'b01);
		one(10, 16'h2000, 2'b01, 2'b00);
		one(9, 16'h1000, 2'b01, 2'b00);
		one(8, 16'h0800, 2'b01, 2'b00);
		one(7, 16'h0400, 2'b01, 2'b00);
		one(6, 16'h0200, 2'b01, 2'b00);
		one(5, 16'h0001, 2'b01, 2'b00);
		serial_path_config = 2'h0;
		one(11, 16'h0000, 2'b00, 2'b00);
		one(9, 16'h0000, 2'b00, 2'b00);
	endtask
	task t_spi;
		interface_select = 1'b0;
		one(4, 16'h0080, 2'b01, 2'b00);
		one(2, 16'h0040, 2'b01, 2'b00);
		one(1, 16'h0020, 2'b01, 2'b00);
		one(0, 16'h0010, 2'b01, 2'b00);
		one(5, 16'h0001, 2'b01, 2'b00);
		one(3, 16'h0000, 2'b10, 2'b00);
		one(12, 16'h0000, 2'b00, 2'b00);
	endtask
	task t_cal_fmea;
		for (int i = 0; i < 5; i++)
		begin
			cal = ass_cal_s'(5'h1 << i);
			tick(2);
			`CHK(alert_summary[3], 1'b1)
			host.rd(`ASS_OFS_SUM, d);
			`CHK(d, 16'h0008)
			host.wr(`ASS_OFS_SUM, 16'h0000);
			`CHK(alert_summary[3], 1'b1)
			cal = '0;
			tick(2);
			`CHK(alert_summary[3], 1'b0)
		end
		for (int i = 0; i < 16; i++)
		begin
			first_fm = 16'h1 << i;
			second_fm = 16'h0000;
			tick(2);
			`CHK(alert_summary[1:0], 2'b01)
			first_fm = 16'h0000;
			second_fm = 16'h8000 >> i;
			tick(2);
			`CHK(alert_summary[1:0], 2'b10)
		end
		first_fm = 16'h0000;
		second_fm = 16'h0000;
		tick(2);
		`CHK(alert_summary[1:0], 2'b00)
	endtask
	task t_balance;
		logic [4:0] m;
		cb_irq_enable = 5'h1f;
		balancing_start = 1'b1;
		tick(1);
		balancing_start = 1'b0;
		tick(1);
		`CHK(balancing_active_state, `ASS_CB_RUN)
		cal = ass_cal_s'(5'h10);
		tick(2);
		`CHK(balancing_active_state, `ASS_CB_ABORT)
		`CHK(balancing_calibration_alert, 1'b1)
		`CHK(alert_summary[2], 1'b1)
		cal = '0;
		cb_alert_clear = 1'b1;
		tick(1);
		cb_alert_clear = 1'b0;
		tick(2);
		`CHK(alert_summary[2], 1'b0)
		for (int i = 0; i < 4; i++)
		begin
			m = (i < 2) ? 5'(1 << i) : 5'(1 << (i + 1));
			cb_alerts = ass_cb_s'(4'h1 << i);
			cb_irq_enable = ~m;
			tick(2);
			`CHK(alert_summary[2], 1'b0)
			cb_irq_enable = 5'h1f;
			tick(2);
			`CHK(alert_summary[2], 1'b1)
			cb_alerts = '0;
			tick(2);
			`CHK(alert_summary[2], 1'b0)
		end
	endtask
	task print_verdict;
		if (bad_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_uart();
		t_spi();
		t_cal_fmea();
		t_balance();
		print_verdict();
	end
	initial
	begin
		#200000;
		bad_count++;
		print_verdict();
	end
endmodule
